/* File: logic/rx_tlp_pkg.sv */
// Constants shared by both ends of the receive TLP user interface.
// Assumes one 250 MHz clock and a synchronous active-high reset.
package rx_tlp_pkg;

  // ----------------------------------------
  // Credit types
  // ----------------------------------------
  localparam int unsigned CT_PH       = 0;
  localparam int unsigned CT_NPH      = 1;
  localparam int unsigned CT_PD       = 2;
  localparam int unsigned CT_NPD      = 3;
  localparam int unsigned CRED_W      = 12;
  localparam int unsigned FC_THRESH   = 8;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned UPDFC_TIME_NS  = 30000;
  localparam int unsigned UPDFC_CYCLES   = UPDFC_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Header decode
  // ----------------------------------------
  localparam logic [4:0] TYPE_MEM    = 5'h00;
  localparam logic [4:0] TYPE_IO     = 5'h02;
  localparam logic [1:0] TYPE_MSG_HI = 2'h2;
  localparam int unsigned FMT_DATA_BIT = 6;

  // ----------------------------------------
  // Controller registers (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_MASK    = 8'h04;
  localparam logic [7:0] REG_CTRL    = 8'h08;
  localparam logic [7:0] REG_DCRED   = 8'h0c;
  localparam logic [7:0] REG_TLPCNT  = 8'h10;
  localparam logic [7:0] REG_LASTBAR = 8'h14;
  localparam int unsigned ST_TLP     = 0;
  localparam int unsigned ST_UNSUPP  = 1;
  localparam int unsigned ST_MALF    = 2;
  localparam int unsigned ST_CRC     = 3;
  localparam int unsigned DCRED_NP_BIT = 8;
  localparam logic [3:0] STATUS_RST  = 4'h0;
  localparam logic [3:0] MASK_RST    = 4'h0;

endpackage

/* File: logic/rx_tlp_if.sv */
// Receive TLP interface joining the core end and the user end.
// Assumes both ends share clk; DW is 64 or 16.
`timescale 1ns/1ns
interface rx_tlp_if #(
  parameter int unsigned DW = 64
);
  logic [DW-1:0]    rx_tlp_payload_bus;
  logic             rx_tlp_first_beat;
  logic             rx_tlp_last_beat;
  logic             rx_upper_dword_only;
  logic             rx_end_crc_fault;
  logic             rx_unsupported_flag;
  logic             rx_badly_formed_flag;
  logic [6:0]       rx_bar_match;
  logic             user_unsupp_nonposted;
  logic             user_unsupp_posted;
  logic [3:0]       user_buffer_full_per_type;
  logic [1:0]       header_credit_consumed_pulse;
  logic [1:0]       data_credit_return_strobe;
  logic [1:0][7:0]  data_credit_return_count;

  modport core (
    output rx_tlp_payload_bus, rx_tlp_first_beat, rx_tlp_last_beat,
    output rx_upper_dword_only, rx_end_crc_fault, rx_unsupported_flag,
    output rx_badly_formed_flag, rx_bar_match,
    input  user_unsupp_nonposted, user_unsupp_posted, user_buffer_full_per_type,
    input  header_credit_consumed_pulse, data_credit_return_strobe,
    input  data_credit_return_count
  );

  modport user (
    input  rx_tlp_payload_bus, rx_tlp_first_beat, rx_tlp_last_beat,
    input  rx_upper_dword_only, rx_end_crc_fault, rx_unsupported_flag,
    input  rx_badly_formed_flag, rx_bar_match,
    output user_unsupp_nonposted, user_unsupp_posted, user_buffer_full_per_type,
    output header_credit_consumed_pulse, data_credit_return_strobe,
    output data_credit_return_count
  );
endinterface

/* File: logic/rx_tlp_core_end.sv */
// Core end: delivers received TLP beats to user logic and runs
// the UpdateFC scheduler from the credits user logic returns.
// Assumes link-side beats come in order, one TLP at a time,
// with no gap between its first and last beat.
`timescale 1ns/1ns
module rx_tlp_core_end
  import rx_tlp_pkg::*;
#(
  parameter int unsigned DW          = 64,
  parameter bit          ECRC_EN     = 1'b1,
  parameter logic [2:0]  BAR64_PAIRS = 3'h0,
  parameter int unsigned UPD_CYCLES  = UPDFC_CYCLES,
  parameter int unsigned THRESH      = FC_THRESH
)(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  rx_tlp_if.core                 rx,
  input  wire logic              link_valid,
  input  wire logic [DW-1:0]     link_bytes,
  input  wire logic              link_first,
  input  wire logic              link_last,
  input  wire logic              link_upper_only,
  input  wire logic              link_crc_bad,
  input  wire logic              link_locked_read,
  input  wire logic              link_bad_format,
  input  wire logic [6:0]        link_addr_hit,
  output logic                   fc_update_valid,
  output logic [1:0]             fc_update_type,
  output logic [CRED_W-1:0]      fc_update_amount
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  localparam int unsigned NB = DW / 8;
  localparam int unsigned TW = $clog2(UPD_CYCLES + 1);

  if (DW != 64 && DW != 16) begin : g_bad_dw
    $error("DW must be 64 or 16");
  end
  if (UPD_CYCLES < 2 || THRESH < 1 || THRESH > 4095) begin : g_bad_cnt
    $error("UPD_CYCLES or THRESH out of range");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte k of link_bytes is the k-th byte in arrival order
  function automatic logic [DW-1:0] lane_order(input logic [DW-1:0] b);
    logic [DW-1:0] o;
    o = '0;
    for (int i = 0; i < NB; i++) begin
      o[DW-1-8*i -: 8] = b[8*i +: 8];
    end
    return o;
  endfunction

  function automatic logic [6:0] bar_fold(input logic [6:0] h);
    logic [6:0] o;
    o = h;
    for (int k = 0; k < 3; k++) begin
      if (BAR64_PAIRS[k]) begin
        o[2*k]   = h[2*k] | h[2*k+1];
        o[2*k+1] = 1'b0;
      end
    end
    return o;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic                        in_tlp;
    logic [DW-1:0]               data;
    logic                        first;
    logic                        last;
    logic                        half;
    logic                        crc;
    logic                        ur;
    logic                        malf;
    logic [6:0]                  bar;
    logic [3:0][CRED_W-1:0]      acc;
    logic [3:0]                  pend;
    logic [3:0]                  full_d;
    logic [TW-1:0]               timer;
    logic                        fc_vld;
    logic [1:0]                  fc_type;
    logic [CRED_W-1:0]           fc_amt;
  } core_state_t;

  core_state_t s;
  core_state_t next_s;

  logic                    active;
  logic                    expire;
  logic                    found;
  logic [3:0]              rise;
  logic [3:0][CRED_W-1:0]  incr;

  always_comb begin
    next_s = s;
    found  = 1'b0;

    // ----------------------------------------
    // Receive beats
    // ----------------------------------------
    active = link_valid && (link_first || s.in_tlp);
    if (active) begin
      next_s.data   = lane_order(link_bytes);
      next_s.first  = link_first;
      next_s.last   = link_last;
      next_s.half   = (DW == 64) && link_upper_only;
      next_s.in_tlp = !link_last;
      if (link_first) begin
        next_s.crc  = ECRC_EN && link_crc_bad;
        next_s.ur   = link_locked_read;
        next_s.malf = link_bad_format;
        next_s.bar  = bar_fold(link_addr_hit);
      end else begin
        // Errors found mid-TLP stay up to the end marker
        next_s.crc  = s.crc | (ECRC_EN && link_crc_bad);
        next_s.malf = s.malf | link_bad_format;
      end
    end else begin
      // Quiet bus between TLPs
      next_s.data  = '0;
      next_s.first = 1'b0;
      next_s.last  = 1'b0;
      next_s.half  = 1'b0;
      next_s.crc   = 1'b0;
      next_s.ur    = 1'b0;
      next_s.malf  = 1'b0;
      next_s.bar   = '0;
      if (link_valid) begin
        next_s.in_tlp = s.in_tlp;
      end
    end

    // ----------------------------------------
    // Credit intake
    // ----------------------------------------
    incr[CT_PH]  = CRED_W'(rx.header_credit_consumed_pulse[0]);
    incr[CT_NPH] = CRED_W'(rx.header_credit_consumed_pulse[1]);
    incr[CT_PD]  = rx.data_credit_return_strobe[0] ?
                   CRED_W'(rx.data_credit_return_count[0]) : '0;
    incr[CT_NPD] = rx.data_credit_return_strobe[1] ?
                   CRED_W'(rx.data_credit_return_count[1]) : '0;

    // Edge only: a held full level must not flood the link
    next_s.full_d = rx.user_buffer_full_per_type;
    rise = rx.user_buffer_full_per_type & ~s.full_d;

    // ----------------------------------------
    // UpdateFC timer
    // ----------------------------------------
    expire = (s.timer == '0);
    if (expire) begin
      next_s.timer = TW'(UPD_CYCLES - 1);
    end else begin
      next_s.timer = s.timer - 1'b1;
    end

    // ----------------------------------------
    // Issue one UpdateFC per cycle, lowest type first
    // ----------------------------------------
    next_s.fc_vld = 1'b0;
    for (int t = 0; t < 4; t++) begin
      next_s.acc[t] = s.acc[t] + incr[t];
      if (s.pend[t] && !found) begin
        found          = 1'b1;
        next_s.fc_vld  = 1'b1;
        next_s.fc_type = 2'(t);
        next_s.fc_amt  = s.acc[t];
        next_s.acc[t]  = incr[t];
        next_s.pend[t] = 1'b0;
      end
      // New causes win over the clear just made
      if (rise[t] || expire || next_s.acc[t] >= CRED_W'(THRESH)) begin
        next_s.pend[t] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.timer <= TW'(UPD_CYCLES - 1);
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rx.rx_tlp_payload_bus   = s.data;
  assign rx.rx_tlp_first_beat    = s.first;
  assign rx.rx_tlp_last_beat     = s.last;
  assign rx.rx_upper_dword_only  = s.half;
  assign rx.rx_end_crc_fault     = s.crc;
  assign rx.rx_unsupported_flag  = s.ur;
  assign rx.rx_badly_formed_flag = s.malf;
  assign rx.rx_bar_match         = s.bar;
  assign fc_update_valid         = s.fc_vld;
  assign fc_update_type          = s.fc_type;
  assign fc_update_amount        = s.fc_amt;

endmodule // rx_tlp_core_end

/* File: logic/rx_tlp_user_end.sv */
// User end: takes TLPs off the receive interface, reports
// unsupported requests, returns credits and raises an interrupt.
// Assumes software on a plain register port, same clock.
`timescale 1ns/1ns
module rx_tlp_user_end
  import rx_tlp_pkg::*;
#(
  parameter int unsigned DW = 64
)(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  rx_tlp_if.user            rx,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata,
  output logic              irq
);

  if (DW != 64 && DW != 16) begin : g_bad_dw
    $error("DW must be 64 or 16");
  end

  typedef struct packed {
    logic             posted;
    logic             uns_np;
    logic             uns_p;
    logic [1:0]       hdr;
    logic [1:0]       dstb;
    logic [1:0][7:0]  dcnt;
    logic [3:0]       full;
    logic [3:0]       status;
    logic [3:0]       mask;
    logic [15:0]      tlp_cnt;
    logic [6:0]       last_bar;
    logic [31:0]      rdata;
    logic             irq;
  } user_state_t;

  user_state_t s;
  user_state_t next_s;

  logic [7:0]  b0;
  logic        is_posted;
  logic        is_msg;
  logic        posted_now;
  logic [3:0]  set;

  always_comb begin
    next_s = s;
    set    = '0;

    // ----------------------------------------
    // Header decode on the start beat
    // ----------------------------------------
    b0         = rx.rx_tlp_payload_bus[DW-1 -: 8];
    is_msg     = (b0[4:3] == TYPE_MSG_HI);
    is_posted  = is_msg || (b0[4:0] == TYPE_MEM && b0[FMT_DATA_BIT]);
    posted_now = rx.rx_tlp_first_beat ? is_posted : s.posted;

    next_s.uns_np = 1'b0;
    next_s.uns_p  = 1'b0;
    next_s.hdr    = '0;
    next_s.dstb   = '0;
    if (rx.rx_tlp_first_beat) begin
      next_s.posted   = is_posted;
      next_s.last_bar = rx.rx_bar_match;
      // Messages are not served here; locked reads and IO requests neither
      next_s.uns_p  = is_msg;
      next_s.uns_np = !is_posted &&
                      (rx.rx_unsupported_flag || b0[4:0] == TYPE_IO);
      set[ST_UNSUPP] = next_s.uns_p | next_s.uns_np;
    end
    if (rx.rx_tlp_last_beat) begin
      next_s.hdr[posted_now ? 0 : 1] = 1'b1;
      next_s.tlp_cnt = s.tlp_cnt + 16'h0001;
      set[ST_TLP]  = 1'b1;
      set[ST_MALF] = rx.rx_badly_formed_flag;
      set[ST_CRC]  = rx.rx_end_crc_fault;
    end

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    next_s.rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        REG_STATUS: next_s.status = s.status & ~reg_wdata[3:0];
        REG_MASK:   next_s.mask   = reg_wdata[3:0];
        REG_CTRL:   next_s.full   = reg_wdata[3:0];
        REG_DCRED: begin
          next_s.dstb[reg_wdata[DCRED_NP_BIT]] = 1'b1;
          next_s.dcnt[reg_wdata[DCRED_NP_BIT]] = reg_wdata[7:0];
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS:  next_s.rdata = {28'h0000000, s.status};
        REG_MASK:    next_s.rdata = {28'h0000000, s.mask};
        REG_CTRL:    next_s.rdata = {28'h0000000, s.full};
        REG_TLPCNT:  next_s.rdata = {16'h0000, s.tlp_cnt};
        REG_LASTBAR: next_s.rdata = {25'h0000000, s.last_bar};
        default:     next_s.rdata = '0;
      endcase
    end
    // Set wins over a same-cycle clear
    next_s.status = next_s.status | set;
    next_s.irq    = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.status <= STATUS_RST;
      s.mask   <= MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rx.user_unsupp_nonposted        = s.uns_np;
  assign rx.user_unsupp_posted           = s.uns_p;
  assign rx.user_buffer_full_per_type    = s.full;
  assign rx.header_credit_consumed_pulse = s.hdr;
  assign rx.data_credit_return_strobe    = s.dstb;
  assign rx.data_credit_return_count     = s.dcnt;
  assign reg_rdata                       = s.rdata;
  assign irq                             = s.irq;

endmodule // rx_tlp_user_end

/* File: tb/tlp_rx_asserts.sv */
// Checker for the receive TLP interface between core end and user end.
// Assumes one clock and a synchronous active-high reset; sees wires only.
`timescale 1ns/1ns
module tlp_rx_asserts #(
  parameter int unsigned DW          = 64,
  parameter logic [2:0]  BAR64_PAIRS = 3'h0
)(
  input wire logic            clk,
  input wire logic            sys_rst,
  input wire logic [DW-1:0]   rx_tlp_payload_bus,
  input wire logic            rx_tlp_first_beat,
  input wire logic            rx_tlp_last_beat,
  input wire logic            rx_upper_dword_only,
  input wire logic            rx_end_crc_fault,
  input wire logic            rx_unsupported_flag,
  input wire logic            rx_badly_formed_flag,
  input wire logic [6:0]      rx_bar_match,
  input wire logic            user_unsupp_nonposted,
  input wire logic            user_unsupp_posted,
  input wire logic [3:0]      user_buffer_full_per_type,
  input wire logic [1:0]      header_credit_consumed_pulse,
  input wire logic [1:0]      data_credit_return_strobe,
  input wire logic [1:0][7:0] data_credit_return_count
);
  // ----------------------------------------
  // Helper: beats after the first of a TLP
  // ----------------------------------------
  localparam logic [6:0] UPPER = {1'b0, BAR64_PAIRS[2], 1'b0, BAR64_PAIRS[1], 1'b0,
                                  BAR64_PAIRS[0], 1'b0};
  logic in_tlp;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_tlp <= 1'b0;
    end else if (rx_tlp_first_beat && !rx_tlp_last_beat) begin
      in_tlp <= 1'b1;
    end else if (rx_tlp_last_beat) begin
      in_tlp <= 1'b0;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_open;  rx_tlp_first_beat && !rx_tlp_last_beat; endsequence
  sequence s_close; rx_tlp_last_beat; endsequence
  sequence s_idle;  !in_tlp && !rx_tlp_first_beat; endsequence

  AST_START_ONCE: assert property (s_open |=> !rx_tlp_first_beat)
    else $error("start marker repeated inside a TLP");
  AST_END_INSIDE: assert property (s_close |-> rx_tlp_first_beat || in_tlp)
    else $error("end marker outside a TLP");
  AST_IDLE_QUIET: assert property (s_idle |-> rx_tlp_payload_bus == '0
    && !rx_tlp_last_beat && !rx_upper_dword_only && !rx_end_crc_fault && !rx_badly_formed_flag)
    else $error("receive outputs active between TLPs");
  AST_BAR_HOLD: assert property (in_tlp |-> $stable(rx_bar_match))
    else $error("bar match changed inside a TLP");
  AST_BAR_PAIR: assert property ((rx_bar_match & UPPER) == 7'h00)
    else $error("upper bar of a 64-bit pair flagged");
  AST_CRC_STICKY: assert property (in_tlp && $past(rx_end_crc_fault)
    |-> rx_end_crc_fault)
    else $error("crc fault dropped inside a TLP");
  AST_LOCK_LEVEL: assert property (in_tlp |-> $stable(rx_unsupported_flag))
    else $error("unsupported flag changed inside a TLP");
  AST_MALF_HELD: assert property (in_tlp && $past(rx_badly_formed_flag)
    |-> rx_badly_formed_flag)
    else $error("malformed flag dropped inside a TLP");
  AST_UR_NP: assert property (rx_tlp_first_beat && rx_unsupported_flag
    |=> user_unsupp_nonposted)
    else $error("locked read not reported as unsupported");
  AST_UR_P: assert property (rx_tlp_first_beat && rx_tlp_payload_bus[DW-4 -: 2] == 2'b10
    |=> user_unsupp_posted && !user_unsupp_nonposted)
    else $error("message not reported as unsupported posted");
  AST_HDR_CREDIT: assert property (s_close |=> $onehot(header_credit_consumed_pulse))
    else $error("no single header credit after TLP end");
  AST_HDR_CAUSE: assert property (header_credit_consumed_pulse != 2'h0
    |-> $past(rx_tlp_last_beat))
    else $error("header credit without a TLP end");
  AST_DATA_STROBE: assert property ($onehot0(data_credit_return_strobe))
    else $error("both data credit strobes at once");
endmodule // tlp_rx_asserts

/* File: tb/tlp_receive_user_interface_tb_top.sv */
// Testbench joining core end and user end over the receive TLP interface.
// Assumes package, interface, both ends and the checker compile first.
`timescale 1ns/1ns
module tlp_receive_user_interface_tb_top;
  import rx_tlp_pkg::*;
  localparam int unsigned UPD   = 200;
  localparam logic [2:0]  PAIRS = 3'h1;
  logic              clk, sys_rst, link_valid, link_first, link_last, link_upper_only;
  logic              link_crc_bad, link_locked_read, link_bad_format;
  logic [63:0]       link_bytes;
  logic [6:0]        link_addr_hit;
  logic              fc_update_valid, reg_wr, reg_rd, irq;
  logic [1:0]        fc_update_type;
  logic [CRED_W-1:0] fc_update_amount;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata;
  int                errors, tests_run, cycles;

  rx_tlp_if #(.DW(64)) rx ();
  rx_tlp_core_end #(.DW(64), .ECRC_EN(1'b1), .BAR64_PAIRS(PAIRS), .UPD_CYCLES(UPD),
    .THRESH(FC_THRESH)) i_rx_tlp_core_end (.clk(clk), .sys_rst(sys_rst), .rx(rx),
    .link_valid(link_valid), .link_bytes(link_bytes), .link_first(link_first),
    .link_last(link_last), .link_upper_only(link_upper_only), .link_crc_bad(link_crc_bad),
    .link_locked_read(link_locked_read), .link_bad_format(link_bad_format),
    .link_addr_hit(link_addr_hit), .fc_update_valid(fc_update_valid),
    .fc_update_type(fc_update_type), .fc_update_amount(fc_update_amount));
  rx_tlp_user_end #(.DW(64)) i_rx_tlp_user_end (.clk(clk), .sys_rst(sys_rst), .rx(rx),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  tlp_rx_asserts #(.DW(64), .BAR64_PAIRS(PAIRS)) i_tlp_rx_asserts (.clk(clk),
    .sys_rst(sys_rst), .rx_tlp_payload_bus(rx.rx_tlp_payload_bus),
    .rx_tlp_first_beat(rx.rx_tlp_first_beat), .rx_tlp_last_beat(rx.rx_tlp_last_beat),
    .rx_upper_dword_only(rx.rx_upper_dword_only), .rx_end_crc_fault(rx.rx_end_crc_fault),
    .rx_unsupported_flag(rx.rx_unsupported_flag),
    .rx_badly_formed_flag(rx.rx_badly_formed_flag), .rx_bar_match(rx.rx_bar_match),
    .user_unsupp_nonposted(rx.user_unsupp_nonposted),
    .user_unsupp_posted(rx.user_unsupp_posted),
    .user_buffer_full_per_type(rx.user_buffer_full_per_type),
    .header_credit_consumed_pulse(rx.header_credit_consumed_pulse),
    .data_credit_return_strobe(rx.data_credit_return_strobe),
    .data_credit_return_count(rx.data_credit_return_count));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard: whole run is a few hundred cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      errors++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic do_reset();
    // Bench starts in reset; only a mid-run reset needs raising
    if (!sys_rst) begin
      @(posedge clk);
      sys_rst <= 1'b1;
    end
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(name, 64'(reg_rdata), 64'(exp));
  endtask
  task automatic wait_fc(input logic [1:0] t, input logic [11:0] amt, input int lo, hi);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (n <= hi && !(fc_update_valid === 1'b1 && fc_update_type === t));
    chk("fc update time", 64'(n >= lo && n <= hi), 64'h1);
    chk("fc update amount", 64'(fc_update_amount), 64'(amt));
  endtask
  // Link bytes in arrival order; beat i is judged one cycle after it is driven
  task automatic tlp(input int n, input logic [7:0] head, input logic [6:0] hit,
                     input logic lock, crc, bad, up);
    logic [63:0] b, pb, rb;
    logic [6:0]  m, eb;
    m = {1'b0, PAIRS[2], 1'b0, PAIRS[1], 1'b0, PAIRS[0], 1'b0};
    eb = (hit & ~m) | ((hit & m) >> 1);
    pb = 64'h0;
    for (int i = 0; i <= n; i++) begin
      @(posedge clk);
      b = 64'h8877665544332210 + 64'(i);
      if (i == 0) b[7:0] = head;
      link_valid <= (i < n);
      link_first <= (i == 0);
      link_last <= (i == n - 1);
      link_bytes <= b;
      link_addr_hit <= hit;
      link_locked_read <= lock;
      link_crc_bad <= crc && (i == 0);
      link_bad_format <= bad && (i == n - 1);
      link_upper_only <= up && (i == n - 1);
      if (i > 0) begin
        #1;
        rb = {<<8{pb}};
        chk("payload bus", rx.rx_tlp_payload_bus, rb);
        chk("first beat", 64'(rx.rx_tlp_first_beat), 64'(i == 1));
        chk("last beat", 64'(rx.rx_tlp_last_beat), 64'(i == n));
        chk("upper dword", 64'(rx.rx_upper_dword_only), 64'(up && i == n));
        chk("crc fault", 64'(rx.rx_end_crc_fault), 64'(crc));
        chk("unsupported", 64'(rx.rx_unsupported_flag), 64'(lock));
        chk("malformed", 64'(rx.rx_badly_formed_flag), 64'(bad && i == n));
        chk("bar match", 64'(rx.rx_bar_match), 64'(eb));
      end
      pb = b;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_fc_thresh();
    do_reset();
    repeat (8) tlp(1, 8'h40, 7'h01, 1'b0, 1'b0, 1'b0, 1'b0);
    wait_fc(2'h0, 12'h8, 0, 10);
    $display("test fc threshold done");
  endtask
  task automatic test_fc_timer();
    do_reset();
    wr(REG_DCRED, 32'h3);
    #1;
    chk("pd strobe", 64'(rx.data_credit_return_strobe), 64'h1);
    chk("pd count", 64'(rx.data_credit_return_count[0]), 64'h3);
    wait_fc(2'h2, 12'h3, UPD - 8, UPD + 4);
    $display("test fc timer done");
  endtask
  task automatic test_full();
    do_reset();
    wr(REG_DCRED, 32'h105);
    wr(REG_CTRL, 32'h8);
    #1;
    chk("buffer full", 64'(rx.user_buffer_full_per_type), 64'h8);
    wait_fc(2'h3, 12'h5, 0, 6);
    // Held full level must not send again
    repeat (4) begin
      @(posedge clk);
      #1;
      chk("held full quiet", 64'(fc_update_valid), 64'h0);
    end
    wr(REG_CTRL, 32'h0);
    $display("test buffer full done");
  endtask
  task automatic test_flags();
    do_reset();
    // Locked read hitting the upper half of the BAR0/1 pair
    tlp(3, 8'h01, 7'h02, 1'b1, 1'b1, 1'b1, 1'b1);
    rd("status", REG_STATUS, 32'hf);
    rd("last bar", REG_LASTBAR, 32'h1);
    chk("irq masked", 64'(irq), 64'h0);
    wr(REG_MASK, 32'h1);
    @(posedge clk);
    #1;
    chk("irq raised", 64'(irq), 64'h1);
    wr(REG_STATUS, 32'hf);
    @(posedge clk);
    #1;
    chk("irq cleared", 64'(irq), 64'h0);
    rd("status cleared", REG_STATUS, 32'h0);
    rd("unmapped", 8'h3c, 32'h0);
    $display("test flags done");
  endtask
  task automatic test_bars();
    logic [7:0] hd [4] = '{8'h30, 8'h40, 8'h00, 8'h02};
    logic [6:0] ht [4] = '{7'h40, 7'h20, 7'h04, 7'h10};
    do_reset();
    for (int k = 0; k < 4; k++) begin
      tlp(k % 3 + 1, hd[k], ht[k], 1'b0, 1'b0, 1'b0, 1'b0);
    end
    // A beat with no start marker outside a TLP is dropped
    @(posedge clk);
    link_valid <= 1'b1;
    @(posedge clk);
    link_valid <= 1'b0;
    #1;
    chk("stray payload", rx.rx_tlp_payload_bus, 64'h0);
    chk("stray first", 64'(rx.rx_tlp_first_beat), 64'h0);
    rd("tlp count", REG_TLPCNT, 32'h4);
    $display("test bars done");
  endtask

  initial begin
    sys_rst = 1'b1;
    {link_valid, link_first, link_last, link_upper_only} = 4'h0;
    {link_crc_bad, link_locked_read, link_bad_format} = 3'h0;
    link_bytes = 64'h0;
    link_addr_hit = 7'h00;
    {reg_wr, reg_rd} = 2'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    errors = 0;
    tests_run = 0;
    cycles = 0;
    test_fc_thresh();
    test_fc_timer();
    test_full();
    test_flags();
    test_bars();
    stop_test();
  end
endmodule // tlp_receive_user_interface_tb_top
